// ### design/wavf_pkg.sv
// constants and types shared by the weight averaging filter
//
// Overview of operation
// R1: each stage averages a configurable count of readings, from 1 to 256
// R2: exactly one output value leaves for every input reading taken
// R3: on override the output is the newest raw reading, not the average
// R4: three cascaded stages; stage one takes readings, later stages the prior output
// R5: each stage keeps a rolling average and forwards it on every input
// R6: all counts at 1 pass every reading through unchanged
// R7: consecutive out-of-band readings are counted; override once count reaches sensitivity
// R8: threshold is in display divisions, tested against the filtered value
// R9: threshold at its disabled value never suspends averaging
// R10: in-band reading clears the counter; override reloads every stage history
package wavf_pkg;
    localparam int DATA_W_DEF = 24; // reading width in converter counts
    localparam int STAGES = 3;
    localparam int CNT_W = 9; // stage count field, holds 1..256
    localparam int HIST_DEPTH = 256; // longest rolling window
    localparam int PTR_W = 8;
    localparam int SENS_W = 8;
    localparam int THR_W = 8;
    localparam logic [CNT_W-1:0] CNT_MIN = 9'h001;
    localparam logic [CNT_W-1:0] CNT_MAX = 9'h100;
    localparam logic [THR_W-1:0] THR_NONE = 8'h00; // threshold value meaning no override
    localparam logic [SENS_W-1:0] SENS_MAX = 8'hFF;
    localparam logic [PTR_W-1:0] FILL_LAST = 8'hFF;
    localparam logic [1:0] STG_LAST = 2'h2;

    typedef enum logic [2:0] {
        WAVF_IDLE,
        WAVF_FILL,
        WAVF_STEP,
        WAVF_DIV,
        WAVF_EMIT
    } wavf_state_t;
endpackage

// ### design/wavf_top.sv
// weight averaging filter: three rolling-average stages with an override path
`timescale 1ns/1ps
`default_nettype none
module wavf_top #(
    parameter int DATA_W = wavf_pkg::DATA_W_DEF
) (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic in_valid_i,
    input wire logic [DATA_W-1:0] in_data_i,
    output logic in_ready_o,
    input wire logic [wavf_pkg::CNT_W-1:0] stage_one_count_i,
    input wire logic [wavf_pkg::CNT_W-1:0] stage_two_count_i,
    input wire logic [wavf_pkg::CNT_W-1:0] stage_three_count_i,
    input wire logic [wavf_pkg::SENS_W-1:0] override_sensitivity_i,
    input wire logic [wavf_pkg::THR_W-1:0] override_threshold_i,
    input wire logic [DATA_W-1:0] division_size_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [DATA_W-1:0] out_data_o,
    output logic out_override_o
);
    localparam int SW = DATA_W + 9; // sum of up to 256 readings with sign
    localparam int TW = DATA_W + wavf_pkg::THR_W;
    localparam int BW = $clog2(SW + 1);

    generate
        if (DATA_W < 4 || DATA_W > 48) begin : g_bad_width
            $error("wavf_top: DATA_W must lie between 4 and 48");
        end
    endgenerate

    // out-of-range counts are held to the legal span
    function automatic logic [wavf_pkg::CNT_W-1:0] clamp_cnt(
        input logic [wavf_pkg::CNT_W-1:0] c);
        if (c == '0) begin
            return wavf_pkg::CNT_MIN;
        end
        if (c > wavf_pkg::CNT_MAX) begin
            return wavf_pkg::CNT_MAX;
        end
        return c;
    endfunction

    function automatic logic [SW-1:0] mag_of(input logic signed [SW-1:0] v);
        return v[SW-1] ? SW'(-v) : SW'(v);
    endfunction

    wavf_pkg::wavf_state_t state_r;
    logic [1:0] stg_r;
    logic [wavf_pkg::PTR_W-1:0] idx_r;
    logic [wavf_pkg::PTR_W-1:0] ptr_r [wavf_pkg::STAGES];
    logic signed [SW-1:0] sum_r [wavf_pkg::STAGES];
    logic signed [DATA_W-1:0] hist [wavf_pkg::STAGES][wavf_pkg::HIST_DEPTH];
    logic signed [DATA_W-1:0] raw_r;
    logic signed [DATA_W-1:0] filt_r;
    logic signed [DATA_W-1:0] x_r;
    logic [wavf_pkg::SENS_W-1:0] oob_cnt_r;
    logic primed_r;
    logic ovr_r;
    logic rdy_r;
    logic [9:0] rem_r;
    logic [SW-1:0] dvd_r;
    logic [BW-1:0] bit_r;
    logic neg_r;
    // output buffer: entry a drives the ports, entry b catches a stalled word
    logic a_v_r;
    logic b_v_r;
    logic [DATA_W-1:0] a_d_r;
    logic [DATA_W-1:0] b_d_r;
    logic a_o_r;
    logic b_o_r;

    logic [wavf_pkg::CNT_W-1:0] n_cnt [wavf_pkg::STAGES];
    logic [wavf_pkg::CNT_W-1:0] n_cur;
    logic take;
    logic signed [DATA_W:0] diff;
    logic [DATA_W:0] diff_mag;
    logic [TW-1:0] thr_cnt;
    logic oob;
    logic [wavf_pkg::SENS_W-1:0] oob_next;
    logic [wavf_pkg::SENS_W-1:0] sens_eff;
    logic go_ovr;
    logic signed [SW-1:0] sum_new;
    logic [9:0] rem_sh;
    logic ge;
    logic push;
    logic pop;

    assign n_cnt[0] = clamp_cnt(stage_one_count_i); // [R1]
    assign n_cnt[1] = clamp_cnt(stage_two_count_i); // [R1]
    assign n_cnt[2] = clamp_cnt(stage_three_count_i); // [R1]
    assign n_cur = n_cnt[stg_r];
    assign take = in_valid_i && rdy_r;

    // band test against the last filtered value, in whole display divisions
    assign diff = $signed({in_data_i[DATA_W-1], in_data_i}) - $signed({filt_r[DATA_W-1], filt_r});
    assign diff_mag = diff[DATA_W] ? (DATA_W+1)'(-diff) : (DATA_W+1)'(diff);
    assign thr_cnt = TW'(override_threshold_i) * TW'(division_size_i); // [R8]
    assign oob = (override_threshold_i != wavf_pkg::THR_NONE)
        && (TW'(diff_mag) > thr_cnt); // [R8] [R9]
    assign oob_next = !oob ? '0
        : (oob_cnt_r == wavf_pkg::SENS_MAX) ? oob_cnt_r : oob_cnt_r + 1'b1; // [R7] [R10]
    assign sens_eff = (override_sensitivity_i == '0) ? 8'h01 : override_sensitivity_i;
    assign go_ovr = oob && (oob_next >= sens_eff); // [R7] [R9]

    // rolling sum: drop the oldest entry of the window, add the newest
    assign sum_new = sum_r[stg_r] - SW'(hist[stg_r][ptr_r[stg_r]]) + SW'(x_r); // [R5]

    // one restoring divide step per cycle; the sum is averaged by the stage count
    assign rem_sh = {rem_r[8:0], dvd_r[SW-1]};
    assign ge = rem_sh >= {1'b0, n_cur};

    // sequencer: takes a reading, walks the stages or reloads them, then emits
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            state_r <= wavf_pkg::WAVF_IDLE;
            stg_r <= 2'h0;
            idx_r <= '0;
            raw_r <= '0;
            filt_r <= '0;
            x_r <= '0;
            oob_cnt_r <= '0;
            primed_r <= 1'b0;
            ovr_r <= 1'b0;
            rdy_r <= 1'b1;
            rem_r <= '0;
            dvd_r <= '0;
            bit_r <= '0;
            neg_r <= 1'b0;
            for (int s = 0; s < wavf_pkg::STAGES; s++) begin
                ptr_r[s] <= '0;
                sum_r[s] <= '0;
            end
        end else begin
            unique case (state_r)
                wavf_pkg::WAVF_IDLE: begin
                    if (take) begin
                        rdy_r <= 1'b0;
                        raw_r <= in_data_i;
                        x_r <= in_data_i; // [R4]
                        stg_r <= 2'h0;
                        idx_r <= '0;
                        // histories are unknown after reset, so the first reading reloads them
                        if (!primed_r || go_ovr) begin
                            ovr_r <= primed_r; // [R3]
                            oob_cnt_r <= '0;
                            state_r <= wavf_pkg::WAVF_FILL;
                        end else begin
                            ovr_r <= 1'b0;
                            oob_cnt_r <= oob_next; // [R7] [R10]
                            state_r <= wavf_pkg::WAVF_STEP;
                        end
                    end
                end
                wavf_pkg::WAVF_FILL: begin
                    // every stage restarts as if it had only ever seen this reading
                    idx_r <= idx_r + 1'b1;
                    if (idx_r == wavf_pkg::FILL_LAST) begin
                        for (int s = 0; s < wavf_pkg::STAGES; s++) begin
                            ptr_r[s] <= '0;
                            sum_r[s] <= SW'(raw_r) * $signed(SW'(n_cnt[s])); // [R10]
                        end
                        filt_r <= raw_r; // [R3]
                        primed_r <= 1'b1;
                        state_r <= wavf_pkg::WAVF_EMIT;
                    end
                end
                wavf_pkg::WAVF_STEP: begin
                    sum_r[stg_r] <= sum_new; // [R5]
                    ptr_r[stg_r] <= (9'(ptr_r[stg_r]) + 9'h001 >= n_cur) ? '0
                        : ptr_r[stg_r] + 1'b1; // [R1]
                    dvd_r <= mag_of(sum_new);
                    neg_r <= sum_new[SW-1];
                    rem_r <= '0;
                    bit_r <= BW'(SW);
                    state_r <= wavf_pkg::WAVF_DIV;
                end
                wavf_pkg::WAVF_DIV: begin
                    if (bit_r != '0) begin
                        rem_r <= ge ? rem_sh - {1'b0, n_cur} : rem_sh;
                        dvd_r <= {dvd_r[SW-2:0], ge};
                        bit_r <= bit_r - 1'b1;
                    end else begin
                        // quotient truncates toward zero; a count of 1 returns the input exactly
                        x_r <= neg_r ? DATA_W'(-dvd_r) : DATA_W'(dvd_r); // [R4] [R6]
                        if (stg_r == wavf_pkg::STG_LAST) begin
                            filt_r <= neg_r ? DATA_W'(-dvd_r) : DATA_W'(dvd_r);
                            state_r <= wavf_pkg::WAVF_EMIT;
                        end else begin
                            stg_r <= stg_r + 1'b1; // [R4]
                            state_r <= wavf_pkg::WAVF_STEP;
                        end
                    end
                end
                wavf_pkg::WAVF_EMIT: begin
                    // the next reading waits until the buffer has room
                    if (!b_v_r) begin
                        rdy_r <= 1'b1;
                        state_r <= wavf_pkg::WAVF_IDLE;
                    end
                end
            endcase
        end
    end

    // history windows; no reset needed since the first reading reloads them
    always_ff @(posedge mclk_i) begin
        if (state_r == wavf_pkg::WAVF_FILL) begin
            for (int s = 0; s < wavf_pkg::STAGES; s++) begin
                hist[s][idx_r] <= raw_r; // [R10]
            end
        end else if (state_r == wavf_pkg::WAVF_STEP) begin
            hist[stg_r][ptr_r[stg_r]] <= x_r; // [R5]
        end
    end

    // two-entry output buffer; a stalled receiver holds the sequencer in emit
    assign push = (state_r == wavf_pkg::WAVF_EMIT) && !b_v_r; // [R2]
    assign pop = a_v_r && out_ready_i;

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            a_v_r <= 1'b0;
            b_v_r <= 1'b0;
            a_d_r <= '0;
            b_d_r <= '0;
            a_o_r <= 1'b0;
            b_o_r <= 1'b0;
        end else if (push && (!a_v_r || (pop && !b_v_r))) begin
            a_v_r <= 1'b1;
            a_d_r <= filt_r; // [R2] [R3]
            a_o_r <= ovr_r;
        end else if (push) begin
            if (pop) begin
                a_d_r <= b_d_r;
                a_o_r <= b_o_r;
            end
            b_v_r <= 1'b1;
            b_d_r <= filt_r;
            b_o_r <= ovr_r;
        end else if (pop) begin
            if (b_v_r) begin
                a_d_r <= b_d_r;
                a_o_r <= b_o_r;
                b_v_r <= 1'b0;
            end else begin
                a_v_r <= 1'b0;
            end
        end
    end

    assign in_ready_o = rdy_r;
    assign out_valid_o = a_v_r;
    assign out_data_o = a_d_r;
    assign out_override_o = a_o_r;
endmodule
`default_nettype wire

// ### testbench/wavf_top_asserts.sv
// port checker for the weight averaging filter
`timescale 1ns/1ps
`default_nettype none
module wavf_top_asserts #(
    parameter int DATA_W = 24
) (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic in_valid_i,
    input wire logic in_ready_o,
    input wire logic [wavf_pkg::SENS_W-1:0] override_sensitivity_i,
    input wire logic [wavf_pkg::THR_W-1:0] override_threshold_i,
    input wire logic out_valid_o,
    input wire logic out_ready_i,
    input wire logic [DATA_W-1:0] out_data_o,
    input wire logic out_override_o
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);
    logic [10:0] low_cnt;
    logic [8:0] tk_cnt;
    logic [2:0] bal;
    logic [8:0] sens_eff;
    assign sens_eff = (override_sensitivity_i == 8'h00) ? 9'h001 : {1'b0, override_sensitivity_i};
    sequence s_take;
        in_valid_i && in_ready_o;
    endsequence
    sequence s_pop;
        out_valid_o && out_ready_i;
    endsequence
    // busy run length, takes since reset, and words owed to the receiver
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            low_cnt <= 11'h000;
            tk_cnt <= 9'h000;
            bal <= 3'h0;
        end else begin
            // saturates so a long stall cannot wrap the busy count
            if (in_ready_o) begin
                low_cnt <= 11'h000;
            end else if (low_cnt != 11'h7FF) begin
                low_cnt <= low_cnt + 11'h001;
            end
            if (in_valid_i && in_ready_o && tk_cnt != 9'h1FF) begin
                tk_cnt <= tk_cnt + 9'h001;
            end
            bal <= bal + 3'(in_valid_i && in_ready_o) - 3'(out_valid_o && out_ready_i);
        end
    end
    AST_TAKE_LOCK: assert property (s_take |=> !in_ready_o)
        else $error("ready stayed high after a take");
    AST_MIN_LATENCY: assert property ($rose(in_ready_o) |-> low_cnt >= 11'h069 && out_valid_o)
        else $error("result came sooner than three stages allow");
    AST_BALANCE: assert property (bal <= 3'h3)
        else $error("more readings owed than the path can hold");
    AST_NO_ORPHAN: assert property (out_valid_o |-> bal != 3'h0)
        else $error("word offered with no reading behind it");
    AST_HOLD: assert property (out_valid_o && !out_ready_i |=> out_valid_o && $stable(out_data_o) && $stable(out_override_o))
        else $error("offered word changed before it was taken");
    AST_RESET_IDLE: assert property ($fell(rst_i) |-> in_ready_o && !out_valid_o)
        else $error("wrong idle outputs after reset");
    AST_NO_OVR: assert property (out_valid_o && override_threshold_i == wavf_pkg::THR_NONE |-> !out_override_o)
        else $error("override with threshold disabled");
    AST_OVR_SENS: assert property (out_valid_o && out_override_o |-> tk_cnt > sens_eff)
        else $error("override before enough readings");
    AST_POP_DRAIN: assert property (s_pop ##0 (bal == 3'h1) |=> !out_valid_o)
        else $error("word offered after the last owed word was taken");
endmodule
`default_nettype wire

// ### testbench/wavf_adc_model.sv
// converter model offering queued readings one at a time
`timescale 1ns/1ps
`default_nettype none
module wavf_adc_model #(
    parameter int DATA_W = 24
) (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic ready_i,
    output logic valid_o,
    output logic [DATA_W-1:0] data_o
);
    logic [DATA_W-1:0] q[$];
    // hold each reading until taken; a released bus shows the inverse, not a stale copy
    // one process owns both outputs, so reset clears them here rather than in an initial
    always @(posedge mclk_i) begin
        if (rst_i) begin
            valid_o <= 1'b0;
            data_o <= '0;
        end else if (valid_o && ready_i) begin
            valid_o <= 1'b0;
            data_o <= ~data_o;
        end else if (!valid_o && q.size() > 0) begin
            valid_o <= 1'b1;
            data_o <= q.pop_front();
        end
    end
endmodule
`default_nettype wire

// ### testbench/wavf_top_tb.sv
// self-checking bench of the weight averaging filter
`timescale 1ns/1ps
`default_nettype none
module wavf_top_tb;
    localparam int W = 24;
    logic mclk_i = 1'b0;
    logic rst_i = 1'b1;
    logic out_ready_i = 1'b1;
    logic stall = 1'b0;
    logic [15:0] lf = 16'h34AA;
    logic [15:0] lf2 = 16'h34AA;
    logic [8:0] c1 = 9'h001, c2 = 9'h001, c3 = 9'h001;
    logic [7:0] sens = 8'h01, thr = 8'h00;
    logic [W-1:0] div = 24'h00000A;
    wire logic in_valid, in_ready, out_valid, out_ovr;
    wire logic [W-1:0] in_data, out_data;
    int error_cnt = 0, n_compared = 0, cyc = 0, i;
    logic [W:0] expq[$];
    int hist[3][256];
    int sum[3], ptr[3], cn[3], last, oob, primed;
    int pat[7] = '{5, 7, 500, 6, 500, 500, 505};
    wavf_adc_model #(.DATA_W(W)) adc (.mclk_i(mclk_i), .rst_i(rst_i), .ready_i(in_ready),
        .valid_o(in_valid), .data_o(in_data));
    wavf_top #(.DATA_W(W)) DUT (.mclk_i(mclk_i), .rst_i(rst_i), .in_valid_i(in_valid),
        .in_data_i(in_data), .in_ready_o(in_ready), .stage_one_count_i(c1),
        .stage_two_count_i(c2), .stage_three_count_i(c3), .override_sensitivity_i(sens),
        .override_threshold_i(thr), .division_size_i(div), .out_valid_o(out_valid),
        .out_ready_i(out_ready_i), .out_data_o(out_data), .out_override_o(out_ovr));
    function automatic logic [15:0] nx(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    function automatic int rnd();
        lf = nx(lf);
        return int'($signed({lf, lf[7:0]}));
    endfunction
    task automatic check(input string nm, input logic [W:0] e, input logic [W:0] s);
        n_compared++;
        if (s !== e) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic report_and_stop();
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // every history takes the same value, so the window sum is value times length
    task automatic reload(input int r);
        for (int s = 0; s < 3; s++) begin
            for (int k = 0; k < 256; k++) hist[s][k] = r;
            sum[s] = r * cn[s];
            ptr[s] = 0;
        end
    endtask
    // reference: band test, override count, then three rolling stages
    task automatic feed(input int r);
        int v;
        logic ov;
        v = r;
        ov = 1'b0;
        if (primed == 0) begin
            primed = 1;
            reload(r);
        end else begin
            if (thr != 0 && (r > last ? r - last : last - r) > int'(thr) * int'(div)) begin
                oob = (oob < 255) ? oob + 1 : 255;
            end else oob = 0;
            if (thr != 0 && oob >= (sens == 0 ? 1 : int'(sens))) begin
                reload(r);
                ov = 1'b1;
                oob = 0;
            end else for (int k = 0; k < 3; k++) begin
                sum[k] += v - hist[k][ptr[k]];
                hist[k][ptr[k]] = v;
                ptr[k] = (ptr[k] + 1) % cn[k];
                v = sum[k] / cn[k];
            end
        end
        last = v;
        expq.push_back({ov, v[W-1:0]});
        adc.q.push_back(r[W-1:0]);
    endtask
    // new settings only under reset, since counts are not re-primed at run time
    task automatic start(input int a, input int b, input int c, input int s, input int th, input int d);
        @(posedge mclk_i);
        rst_i <= 1'b1;
        c1 <= 9'(a);
        c2 <= 9'(b);
        c3 <= 9'(c);
        sens <= 8'(s);
        thr <= 8'(th);
        div <= W'(d);
        cn[0] = a < 1 ? 1 : (a > 256 ? 256 : a);
        cn[1] = b < 1 ? 1 : (b > 256 ? 256 : b);
        cn[2] = c < 1 ? 1 : (c > 256 ? 256 : c);
        primed = 0;
        oob = 0;
        repeat (8) @(posedge mclk_i);
        rst_i <= 1'b0;
    endtask
    task automatic done(input int t);
        for (int w = 0; w < 3000 && expq.size() > 0; w++) @(posedge mclk_i);
        // words still owed when the wait runs out count as a mismatch
        if (expq.size() > 0) begin
            error_cnt++;
            $display("ERROR words_owed expected 0 seen %0d", expq.size());
        end
        $display("test %0d finished", t);
    endtask
    initial forever #10 mclk_i = ~mclk_i;
    // receiver takes words at random moments unless told to stall
    always @(posedge mclk_i) begin
        lf2 <= nx(lf2);
        out_ready_i <= !stall && lf2[0];
    end
    // watchdog and in-order comparison of every word taken
    always @(posedge mclk_i) begin
        cyc++;
        if (cyc > 20000) begin
            error_cnt++;
            $display("ERROR watchdog expected %0d seen %0d", 20000, cyc);
            report_and_stop();
        end
        if (!rst_i && out_valid === 1'b1 && out_ready_i === 1'b1) begin
            if (expq.size() == 0) check("surplus_word", '1, {out_ovr, out_data});
            else check("out_word", expq.pop_front(), {out_ovr, out_data});
        end
    end
    initial begin
        start(1, 1, 1, 1, 0, 10);
        for (i = 0; i < 8; i++) feed(rnd());
        done(1);
        start(2, 3, 4, 1, 0, 10);
        for (i = 0; i < 12; i++) feed(rnd());
        done(2);
        start(256, 1, 2, 2, 2, 10);
        for (i = 0; i < 7; i++) feed(pat[i]);
        done(3);
        stall <= 1'b1;
        start(0, 300, 1, 0, 3, 4);
        for (i = 0; i < 10; i++) feed(rnd() % 64);
        repeat (600) @(posedge mclk_i);
        check("ready_full", '0, {1'b0, {(W-1){1'b0}}, in_ready});
        stall <= 1'b0;
        done(4);
        report_and_stop();
    end
endmodule
bind wavf_top wavf_top_asserts #(.DATA_W(DATA_W)) u_ast (.mclk_i(mclk_i), .rst_i(rst_i),
    .in_valid_i(in_valid_i), .in_ready_o(in_ready_o),
    .override_sensitivity_i(override_sensitivity_i), .override_threshold_i(override_threshold_i),
    .out_valid_o(out_valid_o), .out_ready_i(out_ready_i), .out_data_o(out_data_o),
    .out_override_o(out_override_o));
`default_nettype wire
